// ==== shared/irm_pkg.sv ====
/*
 * Shared constants for the interrupt remap decoder: register offsets and
 * field positions, request address fields, remap table entry layout,
 * fault reason codes and the decoder state type.
 * Assumes a byte-addressed register port with one 32-bit word per register.
 */
package irm_pkg;

    // ==========================================================
    // Register map (byte addresses, one aligned word each)
    localparam logic [7:0] IRM_OFF_CONTROL = 8'h00;
    localparam logic [7:0] IRM_OFF_TABLE_LO = 8'h04;
    localparam logic [7:0] IRM_OFF_TABLE_HI = 8'h08;
    localparam logic [7:0] IRM_OFF_INVAL = 8'h0c;
    localparam logic [7:0] IRM_OFF_FAULT = 8'h10;
    localparam logic [7:0] IRM_OFF_FAULT_CNT = 8'h14;
    localparam logic [7:0] IRM_OFF_CAP = 8'h18;

    localparam int IRM_CTL_REMAP_EN_BIT = 0;
    localparam int IRM_CTL_COMPAT_OK_BIT = 1;
    localparam int IRM_CTL_EXT_MODE_BIT = 2;
    localparam logic [2:0] IRM_CONTROL_RESET = 3'h0;
    localparam logic [31:0] IRM_TABLE_LO_RESET = 32'h0;
    localparam logic [31:0] IRM_TABLE_HI_RESET = 32'h0;
    localparam int IRM_INVAL_ALL_BIT = 0;
    localparam int IRM_INVAL_ONE_BIT = 1;
    localparam int IRM_FAULT_PEND_BIT = 31;

    // ==========================================================
    // Interrupt request address fields
    localparam logic [11:0] IRM_INTR_ID = 12'hfee;
    localparam int IRM_ADDR_FMT_BIT = 4;
    localparam int IRM_ADDR_SUBV_BIT = 3;
    localparam int IRM_ADDR_HMSB_BIT = 2;

    // ==========================================================
    // Remap table entry layout (128 bits)
    localparam int IRM_ENT_PRESENT = 0;
    localparam int IRM_ENT_SUPPRESS = 1;
    localparam int IRM_ENT_DEST_MODE = 2;
    localparam int IRM_ENT_REDIR = 3;
    localparam int IRM_ENT_TRIG = 4;
    localparam int IRM_ENT_DLVY_LO = 5;
    localparam int IRM_ENT_VEC_LO = 16;
    localparam int IRM_ENT_DEST_LO = 32;
    localparam int IRM_ENT_SRCID_LO = 64;
    localparam int IRM_ENT_SRCQ_LO = 80;
    localparam int IRM_ENT_VTYPE_LO = 82;
    localparam logic [127:0] IRM_ENT_RSVD_MASK = 128'hffff_ffff_fff0_0000_0000_0000_ff00_ff00;

    localparam logic [1:0] IRM_VTYPE_NONE = 2'h0;
    localparam logic [1:0] IRM_VTYPE_ID = 2'h1;
    localparam logic [1:0] IRM_VTYPE_BUS = 2'h2;

    // ==========================================================
    // Fault reasons
    localparam logic [7:0] IRM_FLT_RSVD_REQ = 8'h20;
    localparam logic [7:0] IRM_FLT_BOUNDS = 8'h21;
    localparam logic [7:0] IRM_FLT_NOT_PRESENT = 8'h22;
    localparam logic [7:0] IRM_FLT_FETCH_ERR = 8'h23;
    localparam logic [7:0] IRM_FLT_BAD_ENTRY = 8'h24;
    localparam logic [7:0] IRM_FLT_COMPAT_BLK = 8'h25;
    localparam logic [7:0] IRM_FLT_SOURCE = 8'h26;

    typedef enum logic [1:0] {IRM_IDLE, IRM_DECODE, IRM_FETCH, IRM_CHECK} irm_state_e;

endpackage

// ==== verilog/irm_decoder.sv ====
/*
 * Interrupt remap decoder: classifies interrupt writes, passes or blocks
 * compatibility requests, remaps remappable ones through a cached table.
 * Assumes one clock, inputs synchronous to it, and a memory port that
 * answers each entry fetch with one done pulse.
 */
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module irm_decoder
    import irm_pkg::*;
#(
    parameter bit COHERENT = 1'b0,
    parameter int CACHE_DEPTH = 8
)
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_write,
    input wire logic i_reg_read,
    output logic [31:0] o_reg_rdata,
    input wire logic i_req_valid,
    output logic o_req_ready,
    input wire logic [31:0] i_req_addr,
    input wire logic [31:0] i_req_data,
    input wire logic [15:0] i_req_source,
    output logic o_fetch_req,
    output logic [63:0] o_fetch_addr,
    output logic o_fetch_nosnoop,
    input wire logic i_fetch_done,
    input wire logic [127:0] i_fetch_data,
    input wire logic i_fetch_err,
    output logic o_remap_valid,
    output logic [31:0] o_remap_dest,
    output logic [7:0] o_remap_vector,
    output logic [2:0] o_remap_delivery,
    output logic o_remap_dest_mode,
    output logic o_remap_redir_hint,
    output logic o_remap_trigger_mode,
    output logic o_remap_trigger_level,
    output logic o_compat_valid,
    output logic [31:0] o_compat_addr,
    output logic [31:0] o_compat_data,
    output logic o_fault_valid,
    output logic [7:0] o_fault_reason,
    output logic [15:0] o_fault_index
);

    localparam int CW = (CACHE_DEPTH > 1) ? $clog2(CACHE_DEPTH) : 1;

    initial
    begin
        if (CACHE_DEPTH < 2 || (CACHE_DEPTH & (CACHE_DEPTH - 1)) != 0)
            $error("CACHE_DEPTH must be a power of two of at least 2");
    end

    // ==========================================================
    // Registers
    irm_state_e state_ff, nxt_state;
    logic [2:0] control_ff;
    logic [31:0] table_lo_ff, table_hi_ff;
    logic [31:0] req_addr_ff, req_data_ff;
    logic [15:0] req_source_ff;
    logic [15:0] index_ff;
    logic [127:0] entry_ff;
    logic fault_pend_ff;
    logic [7:0] fault_reason_ff;
    logic [15:0] fault_index_ff;
    logic [31:0] fault_cnt_ff;
    logic [31:0] rdata_ff;
    logic [CACHE_DEPTH-1:0] cache_valid_ff;
    logic [127:0] cache_data_ff [CACHE_DEPTH];
    logic [15:0] cache_tag_ff [CACHE_DEPTH];
    logic fault_out_ff, remap_out_ff, compat_out_ff;
    logic [7:0] fault_out_reason_ff;
    logic [127:0] out_entry_ff;

    function automatic logic source_ok(input logic [127:0] ent, input logic [15:0] src);
        logic [15:0] eid;
        logic [15:0] mask;
        eid = ent[IRM_ENT_SRCID_LO +: 16];
        case (ent[IRM_ENT_SRCQ_LO +: 2])
            2'h1: mask = 16'hfffb;
            2'h2: mask = 16'hfff9;
            2'h3: mask = 16'hfff8;
            default: mask = 16'hffff;
        endcase
        case (ent[IRM_ENT_VTYPE_LO +: 2])
            IRM_VTYPE_NONE: source_ok = 1'b1;
            IRM_VTYPE_ID: source_ok = ((eid ^ src) & mask) == 16'h0;
            IRM_VTYPE_BUS: source_ok = (src[15:8] >= eid[15:8]) && (src[15:8] <= eid[7:0]);
            default: source_ok = 1'b0;
        endcase
    endfunction

    // ==========================================================
    // Register port decode
    wire wr_control = i_reg_write && i_reg_addr == IRM_OFF_CONTROL;
    wire wr_table_lo = i_reg_write && i_reg_addr == IRM_OFF_TABLE_LO;
    wire wr_table_hi = i_reg_write && i_reg_addr == IRM_OFF_TABLE_HI;
    wire wr_inval = i_reg_write && i_reg_addr == IRM_OFF_INVAL;
    wire wr_fault = i_reg_write && i_reg_addr == IRM_OFF_FAULT;
    wire inval_all = wr_inval && i_reg_wdata[IRM_INVAL_ALL_BIT];
    wire inval_one = wr_inval && i_reg_wdata[IRM_INVAL_ONE_BIT];
    wire [15:0] inval_index = i_reg_wdata[31:16];
    wire fault_clear = wr_fault && i_reg_wdata[IRM_FAULT_PEND_BIT];

    wire remap_en = control_ff[IRM_CTL_REMAP_EN_BIT];
    wire compat_ok = control_ff[IRM_CTL_COMPAT_OK_BIT];
    wire ext_mode = control_ff[IRM_CTL_EXT_MODE_BIT];

    wire [31:0] rd_mux =
        (i_reg_addr == IRM_OFF_CONTROL) ? {29'h0, control_ff} :
        (i_reg_addr == IRM_OFF_TABLE_LO) ? table_lo_ff :
        (i_reg_addr == IRM_OFF_TABLE_HI) ? table_hi_ff :
        (i_reg_addr == IRM_OFF_FAULT) ? {fault_pend_ff, 7'h0, fault_reason_ff, fault_index_ff} :
        (i_reg_addr == IRM_OFF_FAULT_CNT) ? fault_cnt_ff :
        (i_reg_addr == IRM_OFF_CAP) ? {31'h0, COHERENT} :
        32'h0;

    // ==========================================================
    // Request decode, evaluated in the decode state
    wire is_intr = req_addr_ff[31:20] == IRM_INTR_ID;
    wire fmt_remap = req_addr_ff[IRM_ADDR_FMT_BIT];
    wire sub_valid = req_addr_ff[IRM_ADDR_SUBV_BIT];
    // Bits 1:0 take part in no decode below and only pass out on o_compat_addr
    wire [15:0] handle = {req_addr_ff[IRM_ADDR_HMSB_BIT], req_addr_ff[19:5]};
    wire [15:0] subhandle = sub_valid ? req_data_ff[15:0] : 16'h0;
    wire rsvd_bad = sub_valid && req_data_ff[31:16] != 16'h0;
    // Sum kept 17 bits wide so a wrapping index still fails the bounds check
    wire [16:0] index17 = {1'b0, handle} + {1'b0, subhandle};
    wire [3:0] size_code = table_lo_ff[3:0];
    wire [16:0] entries = 17'h2 << size_code;
    wire in_bounds = index17 < entries;
    wire use_compat = !remap_en || !fmt_remap;
    wire compat_block = remap_en && (ext_mode || !compat_ok);
    wire [CW-1:0] slot = index17[CW-1:0];
    wire cache_hit = cache_valid_ff[slot] && cache_tag_ff[slot] == index17[15:0];
    wire [CW-1:0] fill_slot = index_ff[CW-1:0];

    // ==========================================================
    // Entry checks, evaluated in the check state
    wire ent_present = entry_ff[IRM_ENT_PRESENT];
    wire ent_suppress = entry_ff[IRM_ENT_SUPPRESS];
    wire ent_bad = (entry_ff & IRM_ENT_RSVD_MASK) != 128'h0
        || entry_ff[IRM_ENT_VTYPE_LO +: 2] == 2'h3;
    wire ent_src_ok = source_ok(entry_ff, req_source_ff);

    // ==========================================================
    // Next state and event selection
    logic ev_fault, ev_qual, ev_remap, ev_compat, ld_cache, ld_fetch;
    logic [7:0] ev_reason;

    always_comb
    begin
        nxt_state = state_ff;
        ev_fault = 1'b0;
        ev_qual = 1'b0;
        ev_remap = 1'b0;
        ev_compat = 1'b0;
        ev_reason = 8'h0;
        ld_cache = 1'b0;
        ld_fetch = 1'b0;
        case (state_ff)
            IRM_IDLE:
            begin
                if (i_req_valid)
                    nxt_state = IRM_DECODE;
            end
            IRM_DECODE:
            begin
                nxt_state = IRM_IDLE;
                if (!is_intr)
                    nxt_state = IRM_IDLE;
                else if (use_compat && compat_block)
                begin
                    ev_fault = 1'b1;
                    ev_reason = IRM_FLT_COMPAT_BLK;
                end
                else if (use_compat)
                    ev_compat = 1'b1;
                else if (rsvd_bad)
                begin
                    ev_fault = 1'b1;
                    ev_reason = IRM_FLT_RSVD_REQ;
                end
                else if (!in_bounds)
                begin
                    ev_fault = 1'b1;
                    ev_reason = IRM_FLT_BOUNDS;
                end
                else if (cache_hit)
                begin
                    ld_cache = 1'b1;
                    nxt_state = IRM_CHECK;
                end
                else
                    nxt_state = IRM_FETCH;
            end
            IRM_FETCH:
            begin
                if (i_fetch_done && i_fetch_err)
                begin
                    ev_fault = 1'b1;
                    ev_reason = IRM_FLT_FETCH_ERR;
                    nxt_state = IRM_IDLE;
                end
                else if (i_fetch_done)
                begin
                    ld_fetch = 1'b1;
                    nxt_state = IRM_CHECK;
                end
            end
            IRM_CHECK:
            begin
                nxt_state = IRM_IDLE;
                ev_qual = 1'b1;
                if (!ent_present)
                begin
                    ev_fault = 1'b1;
                    ev_reason = IRM_FLT_NOT_PRESENT;
                end
                else if (ent_bad)
                begin
                    ev_fault = 1'b1;
                    ev_reason = IRM_FLT_BAD_ENTRY;
                end
                else if (!ent_src_ok)
                begin
                    ev_fault = 1'b1;
                    ev_reason = IRM_FLT_SOURCE;
                end
                else
                    ev_remap = 1'b1;
            end
            default:
                nxt_state = IRM_IDLE;
        endcase
    end

    // Qualified faults still block, they are only kept quiet
    wire fault_report = ev_fault && !(ev_qual && ent_suppress);
    wire nxt_fault_pend = fault_report || (fault_pend_ff && !fault_clear);

    // ==========================================================
    // Control and status registers
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            state_ff <= IRM_IDLE;
            control_ff <= IRM_CONTROL_RESET;
            table_lo_ff <= IRM_TABLE_LO_RESET;
            table_hi_ff <= IRM_TABLE_HI_RESET;
            fault_pend_ff <= 1'b0;
            fault_cnt_ff <= 32'h0;
            rdata_ff <= 32'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            if (wr_control)
                control_ff <= i_reg_wdata[2:0];
            if (wr_table_lo)
                table_lo_ff <= i_reg_wdata;
            if (wr_table_hi)
                table_hi_ff <= i_reg_wdata;
            fault_pend_ff <= nxt_fault_pend;
            if (fault_report)
                fault_cnt_ff <= fault_cnt_ff + 32'h1;
            rdata_ff <= i_reg_read ? rd_mux : 32'h0;
        end
    end

    // ==========================================================
    // Request capture and entry holding
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            req_addr_ff <= 32'h0;
            req_data_ff <= 32'h0;
            req_source_ff <= 16'h0;
            index_ff <= 16'h0;
            entry_ff <= 128'h0;
            fault_reason_ff <= 8'h0;
            fault_index_ff <= 16'h0;
        end
        else
        begin
            if (state_ff == IRM_IDLE && i_req_valid)
            begin
                req_addr_ff <= i_req_addr;
                req_data_ff <= i_req_data;
                req_source_ff <= i_req_source;
            end
            if (state_ff == IRM_DECODE)
                index_ff <= index17[15:0];
            if (ld_cache)
                entry_ff <= cache_data_ff[slot];
            else if (ld_fetch)
                entry_ff <= i_fetch_data;
            if (fault_report)
            begin
                fault_reason_ff <= ev_reason;
                fault_index_ff <= (state_ff == IRM_DECODE) ? index17[15:0] : index_ff;
            end
        end
    end

    // ==========================================================
    // Entry cache; an invalidate-all in the fill cycle wins, a single invalidate then matches only the slot's old tag
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            cache_valid_ff <= '0;
        else
        begin
            for (int i = 0; i < CACHE_DEPTH; i++)
            begin
                if (inval_all || (inval_one && cache_tag_ff[i] == inval_index))
                    cache_valid_ff[i] <= 1'b0;
                else if (ld_fetch && fill_slot == CW'(i))
                    cache_valid_ff[i] <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (ld_fetch)
        begin
            cache_data_ff[fill_slot] <= i_fetch_data;
            cache_tag_ff[fill_slot] <= index_ff;
        end
    end

    // ==========================================================
    // Output events, one cycle each
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            fault_out_ff <= 1'b0;
            fault_out_reason_ff <= 8'h0;
            remap_out_ff <= 1'b0;
            compat_out_ff <= 1'b0;
            out_entry_ff <= 128'h0;
        end
        else
        begin
            fault_out_ff <= fault_report;
            fault_out_reason_ff <= ev_reason;
            remap_out_ff <= ev_remap;
            compat_out_ff <= ev_compat;
            if (ev_remap)
                out_entry_ff <= entry_ff;
        end
    end

    assign o_reg_rdata = rdata_ff;
    assign o_req_ready = state_ff == IRM_IDLE;
    assign o_fetch_req = state_ff == IRM_FETCH;
    assign o_fetch_addr = {table_hi_ff, table_lo_ff[31:12], 12'h0} + {44'h0, index_ff, 4'h0};
    assign o_fetch_nosnoop = !COHERENT;
    assign o_remap_valid = remap_out_ff;
    assign o_remap_dest = out_entry_ff[IRM_ENT_DEST_LO +: 32];
    assign o_remap_vector = out_entry_ff[IRM_ENT_VEC_LO +: 8];
    assign o_remap_delivery = out_entry_ff[IRM_ENT_DLVY_LO +: 3];
    assign o_remap_dest_mode = out_entry_ff[IRM_ENT_DEST_MODE];
    assign o_remap_redir_hint = out_entry_ff[IRM_ENT_REDIR];
    assign o_remap_trigger_mode = out_entry_ff[IRM_ENT_TRIG];
    assign o_remap_trigger_level = 1'b1;
    assign o_compat_valid = compat_out_ff;
    assign o_compat_addr = req_addr_ff;
    assign o_compat_data = req_data_ff;
    assign o_fault_valid = fault_out_ff;
    assign o_fault_reason = fault_out_reason_ff;
    assign o_fault_index = fault_index_ff;

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence s_decode_remap;
        state_ff == IRM_DECODE && is_intr && !use_compat;
    endsequence

    sequence s_fetch_wait;
        o_fetch_req && !i_fetch_done;
    endsequence

    a_window_filter: assert property (
        state_ff == IRM_DECODE && !is_intr |=> !o_compat_valid && !o_fault_valid && !o_remap_valid)
        else $error("non-interrupt address produced an event");
    a_compat_when_off: assert property (
        state_ff == IRM_DECODE && is_intr && !remap_en |=> o_compat_valid && !o_fault_valid)
        else $error("request not passed through with remapping off");
    a_compat_blocked: assert property (
        state_ff == IRM_DECODE && is_intr && remap_en && !fmt_remap && (ext_mode || !compat_ok)
        |=> o_fault_valid && o_fault_reason == IRM_FLT_COMPAT_BLK && !o_compat_valid)
        else $error("compat request not blocked");
    a_reserved_data: assert property (
        s_decode_remap ##0 rsvd_bad |=> o_fault_valid && o_fault_reason == IRM_FLT_RSVD_REQ)
        else $error("reserved data bits not faulted");
    a_bounds_check: assert property (
        s_decode_remap ##0 !rsvd_bad && !in_bounds
        |=> o_fault_valid && o_fault_reason == IRM_FLT_BOUNDS && state_ff == IRM_IDLE)
        else $error("out of range index not blocked");
    a_fetch_holds: assert property (
        s_fetch_wait |=> o_fetch_req && $stable(o_fetch_addr))
        else $error("entry fetch dropped before done");
    a_not_present: assert property (
        state_ff == IRM_CHECK && !ent_present && !ent_suppress
        |=> o_fault_valid && o_fault_reason == IRM_FLT_NOT_PRESENT && !o_remap_valid)
        else $error("absent entry not faulted");
    a_fault_suppressed: assert property (
        state_ff == IRM_CHECK && ent_suppress && (!ent_present || ent_bad || !ent_src_ok)
        |=> !o_fault_valid && !o_remap_valid)
        else $error("qualified fault reported despite suppression");
    a_trigger_level: assert property (
        o_remap_valid |-> o_remap_trigger_level && $past(state_ff) == IRM_CHECK)
        else $error("remapped interrupt without trigger level");
    a_blocked_silent: assert property (
        o_fault_valid |-> !o_remap_valid && !o_compat_valid)
        else $error("blocked request forwarded");

endmodule

// ==== tb/irm_table_mem.sv ====
/* Remap table memory model: answers each entry fetch with one done pulse.
   Assumes the fetch request holds until done; the bench fills mem directly. */
`timescale 1ns/1ps
module irm_table_mem
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_fetch_req,
    input wire logic [63:0] i_fetch_addr,
    input wire logic i_slow,
    input wire logic i_bad,
    output logic o_done,
    output logic o_err,
    output logic [127:0] o_data
);
    logic [127:0] mem [16];
    logic [127:0] q_ff;
    logic [2:0] cnt_ff;
    // Stale data is inverted so a late sample cannot pass
    assign o_data = o_done ? q_ff : ~q_ff;
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            cnt_ff <= 3'h0;
            o_done <= 1'b0;
            o_err <= 1'b0;
            q_ff <= 128'h0;
        end
        else
        begin
            o_done <= 1'b0;
            o_err <= 1'b0;
            if (i_fetch_req && cnt_ff == 3'h0 && !o_done)
                cnt_ff <= i_slow ? 3'h5 : 3'h1;
            else if (cnt_ff != 3'h0)
                cnt_ff <= cnt_ff - 3'h1;
            if (cnt_ff == 3'h1)
            begin
                o_done <= 1'b1;
                o_err <= i_bad;
                q_ff <= mem[i_fetch_addr[7:4]];
            end
        end
    end
endmodule

// ==== tb/irm_decoder_bench.sv ====
/* Bench for irm_decoder: register and request tasks against the table model.
   Assumes the shared package and the table memory model. */
`timescale 1ns/1ps
module irm_decoder_bench;
    import irm_pkg::*;
    logic i_clk, i_reset, i_reg_write, i_reg_read, i_req_valid, slow, bad;
    logic [7:0] i_reg_addr, o_remap_vector, o_fault_reason;
    logic [31:0] i_reg_wdata, i_req_addr, i_req_data, o_reg_rdata, o_remap_dest;
    logic [31:0] o_compat_addr, o_compat_data;
    logic [15:0] i_req_source, o_fault_index;
    logic [127:0] i_fetch_data;
    logic [63:0] o_fetch_addr, last_addr;
    logic [2:0] o_remap_delivery;
    logic o_req_ready, o_fetch_req, o_fetch_nosnoop, i_fetch_done, i_fetch_err;
    logic o_remap_valid, o_remap_trigger_level, o_compat_valid, o_fault_valid;
    logic o_remap_dest_mode, o_remap_redir_hint, o_remap_trigger_mode;
    logic [65:0] got;
    int err_count = 0;
    int checked = 0;
    int fetches = 0;
    irm_decoder uut (.i_clk, .i_reset, .i_reg_addr, .i_reg_wdata, .i_reg_write, .i_reg_read,
        .o_reg_rdata, .i_req_valid, .o_req_ready, .i_req_addr, .i_req_data, .i_req_source,
        .o_fetch_req, .o_fetch_addr, .o_fetch_nosnoop, .i_fetch_done, .i_fetch_data,
        .i_fetch_err, .o_remap_valid, .o_remap_dest, .o_remap_vector, .o_remap_delivery,
        .o_remap_dest_mode, .o_remap_redir_hint, .o_remap_trigger_mode,
        .o_remap_trigger_level, .o_compat_valid, .o_compat_addr, .o_compat_data,
        .o_fault_valid, .o_fault_reason, .o_fault_index);
    irm_table_mem tmem (.i_clk, .i_reset, .i_fetch_req(o_fetch_req), .i_fetch_addr(o_fetch_addr),
        .i_slow(slow), .i_bad(bad), .o_done(i_fetch_done), .o_err(i_fetch_err),
        .o_data(i_fetch_data));
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk)
        if (i_fetch_done === 1'b1)
        begin
            fetches <= fetches + 1;
            last_addr <= o_fetch_addr;
        end
    // ====================================================
    // Helpers
    function automatic logic [31:0] ia(input logic [15:0] h, input logic sv);
        return {IRM_INTR_ID, h[14:0], 1'b1, sv, h[15], 2'b11};
    endfunction
    function automatic logic [127:0] ent(input logic [7:0] v, input logic [15:0] s,
        input logic [1:0] vt, input logic [7:0] low);
        return {44'h0, vt, 2'h0, s, 24'hab0000, v, 8'h0, v, 8'h0, low};
    endfunction
    function automatic logic [65:0] rm(input logic [127:0] e);
        return {2'h2, 17'h0, e[4:2], 1'b1, e[7:5], e[23:16], e[63:32]};
    endfunction
    function automatic logic [65:0] flt(input logic [7:0] r);
        return {2'h3, 56'h0, r};
    endfunction
    task automatic chk(input logic [65:0] g, input logic [65:0] e);
        checked++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_write <= 1'b1;
        @(posedge i_clk);
        i_reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_read <= 1'b1;
        @(posedge i_clk);
        i_reg_read <= 1'b0;
        #1 chk(o_reg_rdata, e);
    endtask
    // Ready is high on entry, so the request is taken at the second edge
    task automatic req(input logic [31:0] a, input logic [31:0] d, input logic [15:0] s,
        input logic [65:0] e);
        int n;
        @(posedge i_clk);
        i_req_addr <= a;
        i_req_data <= d;
        i_req_source <= s;
        i_req_valid <= 1'b1;
        @(posedge i_clk);
        i_req_valid <= 1'b0;
        got = 66'h0;
        for (n = 0; n < 40; n++)
        begin
            @(posedge i_clk);
            #1;
            if (o_compat_valid === 1'b1)
                got = {2'h1, o_compat_addr, o_compat_data};
            if (o_remap_valid === 1'b1)
                got = {2'h2, 17'h0, o_remap_trigger_mode, o_remap_redir_hint, o_remap_dest_mode,
                    o_remap_trigger_level, o_remap_delivery, o_remap_vector, o_remap_dest};
            if (o_fault_valid === 1'b1)
                got = flt(o_fault_reason);
            if (o_req_ready === 1'b1)
                break;
        end
        if (n == 40)
        begin
            err_count++;
            complete_run();
        end
        chk(got, e);
    endtask
    // ====================================================
    // Main sequence
    initial
    begin
        i_reset = 1'b1;
        {i_reg_write, i_reg_read, i_req_valid, slow, bad} = 5'h0;
        {i_reg_addr, i_reg_wdata, i_req_addr, i_req_data, i_req_source} = 120'h0;
        repeat (6) @(posedge i_clk);
        i_reset <= 1'b0;
        #1 chk(o_req_ready, 1'b1);
        chk(o_remap_trigger_level, 1'b1);
        rd(IRM_OFF_CONTROL, 32'h0);
        wr(IRM_OFF_CAP, 32'hffffffff);
        rd(IRM_OFF_CAP, 32'h0);
        rd(8'h1c, 32'h0);
        req(ia(16'h1, 1'b1), 32'h10000, 16'h0, {2'h1, ia(16'h1, 1'b1), 32'h10000});
        req(32'hfed00010, 32'h5, 16'h0, 66'h0);
        wr(IRM_OFF_TABLE_LO, 32'h1002);
        wr(IRM_OFF_CONTROL, 32'h3);
        req(32'hfee01000, 32'h41, 16'h0, {2'h1, 32'hfee01000, 32'h41});
        wr(IRM_OFF_CONTROL, 32'h1);
        req(32'hfee01000, 32'h41, 16'h0, flt(IRM_FLT_COMPAT_BLK));
        wr(IRM_OFF_CONTROL, 32'h7);
        req(32'hfee01000, 32'h41, 16'h0, flt(IRM_FLT_COMPAT_BLK));
        wr(IRM_OFF_CONTROL, 32'h3);
        $display("test format and compatibility done");
        req(ia(16'h1, 1'b1), 32'h10000, 16'h0, flt(IRM_FLT_RSVD_REQ));
        req(ia(16'h8000, 1'b0), 32'h0, 16'h0, flt(IRM_FLT_BOUNDS));
        req(ia(16'h6, 1'b1), 32'h2, 16'h0, flt(IRM_FLT_BOUNDS));
        rd(IRM_OFF_FAULT, 32'h80210008);
        chk(o_fault_index, 16'h8);
        rd(IRM_OFF_FAULT_CNT, 32'h5);
        wr(IRM_OFF_FAULT, 32'h80000000);
        rd(IRM_OFF_FAULT, 32'h00210008);
        tmem.mem[1] = ent(8'h31, 16'h0100, IRM_VTYPE_ID, 8'ha1);
        tmem.mem[2] = ent(8'h32, 16'h0, IRM_VTYPE_NONE, 8'h00);
        tmem.mem[3] = ent(8'h33, 16'h0, IRM_VTYPE_NONE, 8'h02);
        tmem.mem[4] = ent(8'h34, 16'h0, IRM_VTYPE_NONE, 8'h01) | (128'h1 << 100);
        tmem.mem[5] = ent(8'h55, 16'h0, IRM_VTYPE_NONE, 8'h5d);
        tmem.mem[6] = ent(8'h36, 16'h0, 2'h3, 8'h01);
        tmem.mem[7] = ent(8'h37, 16'h0100, IRM_VTYPE_ID, 8'h01);
        req(ia(16'h1, 1'b0), 32'hffffffff, 16'h0100, rm(tmem.mem[1]));
        chk(last_addr, 64'h1010);
        chk(o_fetch_nosnoop, 1'b1);
        req(ia(16'h1, 1'b0), 32'h0, 16'h0100, rm(tmem.mem[1]));
        chk(fetches, 1);
        slow <= 1'b1;
        req(ia(16'h2, 1'b1), 32'h3, 16'h0, rm(tmem.mem[5]));
        slow <= 1'b0;
        tmem.mem[1] = ent(8'h77, 16'h0100, IRM_VTYPE_ID, 8'ha1);
        wr(IRM_OFF_INVAL, 32'h1);
        req(ia(16'h1, 1'b0), 32'h0, 16'h0100, rm(tmem.mem[1]));
        tmem.mem[1] = ent(8'h78, 16'h0100, IRM_VTYPE_ID, 8'ha1);
        wr(IRM_OFF_INVAL, 32'h00010002);
        req(ia(16'h1, 1'b0), 32'h0, 16'h0100, rm(tmem.mem[1]));
        $display("test remap done");
        req(ia(16'h2, 1'b0), 32'h0, 16'h0, flt(IRM_FLT_NOT_PRESENT));
        req(ia(16'h3, 1'b0), 32'h0, 16'h0, 66'h0);
        req(ia(16'h4, 1'b0), 32'h0, 16'h0, flt(IRM_FLT_BAD_ENTRY));
        req(ia(16'h6, 1'b0), 32'h0, 16'h0, flt(IRM_FLT_BAD_ENTRY));
        req(ia(16'h7, 1'b0), 32'h0, 16'h0200, flt(IRM_FLT_SOURCE));
        bad <= 1'b1;
        req(ia(16'h0, 1'b0), 32'h0, 16'h0, flt(IRM_FLT_FETCH_ERR));
        bad <= 1'b0;
        $display("test entry faults done");
        complete_run();
    end
endmodule
